/* File: shared/csi_pkg.sv */
package csi_pkg;
	// ----------------------------------------
	// Stack geometry
	// ----------------------------------------
	localparam int STACK_DEPTH = 16;
	localparam int PC_W        = 16;
	localparam int SP_W        = 4;
	localparam logic [3:0] SP_RESET = 4'h0;
	localparam logic [3:0] SP_TOP   = 4'hf;

	// ----------------------------------------
	// Indirect addressing
	// ----------------------------------------
	localparam int PTR_W = 8;
	localparam logic [7:0] PTR_RESET = 8'h00;
	localparam logic [7:0] PTR_NULL  = 8'h00;
	localparam logic [7:0] PORT_ZERO_ADDR = 8'h00;
	localparam logic [7:0] PORT_ONE_ADDR  = 8'h08;
	localparam int MODE1_HI = 7;
	localparam int MODE1_LO = 6;
	localparam int MODE0_HI = 5;
	localparam int MODE0_LO = 4;
	localparam logic [1:0] STEP_DEC = 2'h0;
	localparam logic [1:0] STEP_INC = 2'h1;

	// ----------------------------------------
	// Table pointer and latch
	// ----------------------------------------
	localparam logic [15:0] TBL_RESET = 16'h0000;

	typedef enum logic [1:0] {
		CSI_TGT_NONE,
		CSI_TGT_P0,
		CSI_TGT_P1
	} csi_tgt_t;
endpackage

/* File: shared/csi_stack_if.sv */
`timescale 1ns/1ps
interface csi_stack_if;
	logic                  wr_en;
	logic [3:0]            wr_addr;
	logic [15:0]           wr_data;
	logic [3:0]            rd_addr;
	logic [15:0]           rd_data;

	modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
	modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

/* File: verilog/csi_stack_mem.sv */
`timescale 1ns/1ps
module csi_stack_mem #(
	parameter int DEPTH = csi_pkg::STACK_DEPTH
) (
	input  wire logic clk_sys,
	csi_stack_if.mem  port
);
	logic [15:0] mem [DEPTH];
	logic [15:0] rd_q;

	// Registered read; the memory itself needs no reset
	always_ff @(posedge clk_sys) begin
		if (port.wr_en) begin
			mem[port.wr_addr] <= port.wr_data;
		end
		rd_q <= mem[port.rd_addr];
	end

	assign port.rd_data = rd_q;
endmodule

/* File: verilog/csi_core.sv */
`timescale 1ns/1ps
// Summary of operation
// - Sixteen-entry, sixteen-bit return stack kept outside program and data spaces.
// - Stack pointer has no read or write path; only push and pop move it.
// - Call or acknowledged interrupt pushes the program counter.
// - Return, return-with-literal or interrupt return pops into the program counter.
// - Push and pop leave the pc high holding latch untouched.
// - Stack is circular; pointer resets to zero.
// - Available flag set at reset, cleared whenever pointer equals Fh.
// - Wrap from Fh to 0h locks the available flag clear until reset.
// - Pop before any push clears flag; a following push locks it clear.
// - Seventeenth push overwrites first entry, eighteenth the second, and onward.
// - No underflow flag; underflow shows only through the available flag.
// - Indirect ports have no storage; access goes to the pointer's address.
// - Pointers are 8 bits; bank select chooses bank for banked targets.
// - Indirect read of a port gives zero and sets zero; write is NOP.
// - Pointer at zero: read gives zero and sets zero; write is NOP.
// - Step modes sit in status bits 7:6 (pointer one) and 5:4 (zero).
// - Mode 00 decrements, 01 increments, 1x holds the pointer.
// - Pointer stepping never changes arithmetic status flags.
// - Indirect peripheral/file moves complete in a single instruction cycle.
// - Table pointer low and high bytes form a 16-bit program address.
// - A 16-bit table latch in two bytes, mapped nowhere, buffers transfers.
module csi_core (
	input  wire logic        clk_sys,
	input  wire logic        sys_rst,
	input  wire logic        call_exec,
	input  wire logic        intr_vector,
	input  wire logic        return_exec,
	input  wire logic        return_with_literal_instr,
	input  wire logic        interrupt_return_instr,
	input  wire logic [15:0] pc_in,
	output logic      [15:0] pc_pop,
	output logic             pc_pop_valid,
	output logic             stack_available_flag,
	input  wire logic [7:0]  arithmetic_status_register,
	input  wire logic [7:0]  bank_select_value,
	input  wire logic        ptr0_wr,
	input  wire logic        ptr1_wr,
	input  wire logic [7:0]  ptr_wr_data,
	input  wire logic        ind_rd,
	input  wire logic        ind_wr,
	input  wire logic        ind_sel,
	input  wire logic [7:0]  ind_wr_data,
	input  wire logic [7:0]  mem_rd_data,
	output logic      [7:0]  indirect_pointer_zero,
	output logic      [7:0]  indirect_pointer_one,
	output logic      [7:0]  mem_addr,
	output logic      [7:0]  mem_bank,
	output logic             mem_rd,
	output logic             mem_wr,
	output logic      [7:0]  mem_wr_data,
	output logic      [7:0]  ind_rd_data,
	output logic             ind_rd_valid,
	output logic             zero_flag_set,
	input  wire logic        table_pointer_low_wr,
	input  wire logic        table_pointer_high_wr,
	input  wire logic [7:0]  tbl_wr_data,
	input  wire logic        table_latch_low_wr,
	input  wire logic        table_latch_high_wr,
	input  wire logic        table_latch_load,
	input  wire logic [15:0] table_latch_load_data,
	input  wire logic        table_pointer_step,
	output logic      [7:0]  table_pointer_low,
	output logic      [7:0]  table_pointer_high,
	output logic      [15:0] table_pointer,
	output logic      [7:0]  table_latch_high,
	output logic      [7:0]  table_latch_low,
	output logic      [15:0] table_latch
);
	// ----------------------------------------
	// State
	// ----------------------------------------
	typedef struct packed {
		logic [3:0]  sp;
		logic        avail;
		logic        locked;
		logic        pushed;
		logic        popped;
		logic        pop_pend;
		logic        pc_pop_valid;
		logic [7:0]  p0;
		logic [7:0]  p1;
		logic [7:0]  mem_addr;
		logic [7:0]  mem_bank;
		logic        mem_rd;
		logic        mem_wr;
		logic [7:0]  mem_wr_data;
		logic        rd_pend;
		logic        rd_null;
		logic [7:0]  ind_rd_data;
		logic        ind_rd_valid;
		logic        zero_flag_set;
		logic [15:0] tptr;
		logic [15:0] tlat;
	} csi_state_t;

	csi_state_t st;
	csi_state_t next_st;
	csi_stack_if sif ();

	csi_stack_mem #(.DEPTH(csi_pkg::STACK_DEPTH)) u_mem (
		.clk_sys (clk_sys),
		.port    (sif.mem)
	);

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	function automatic logic [7:0] csi_step(input logic [7:0] p, input logic [1:0] mode);
		logic [7:0] r;
		r = p;
		if (mode == csi_pkg::STEP_DEC) begin
			r = p - 8'h01;
		end else if (mode == csi_pkg::STEP_INC) begin
			r = p + 8'h01;
		end
		return r;
	endfunction

	function automatic logic csi_is_port(input logic [7:0] a);
		return (a == csi_pkg::PORT_ZERO_ADDR) || (a == csi_pkg::PORT_ONE_ADDR);
	endfunction

	logic       push;
	logic       pop;
	logic [7:0] cur_ptr;
	logic       bad_tgt;
	logic [1:0] cur_mode;

	assign push = call_exec | intr_vector;
	assign pop  = return_exec | return_with_literal_instr | interrupt_return_instr;
	assign cur_ptr  = ind_sel ? st.p1 : st.p0;
	assign cur_mode = ind_sel ? arithmetic_status_register[csi_pkg::MODE1_HI:csi_pkg::MODE1_LO]
	                          : arithmetic_status_register[csi_pkg::MODE0_HI:csi_pkg::MODE0_LO];
	// Null pointer equals port zero's address, so both checks fold together
	assign bad_tgt  = (cur_ptr == csi_pkg::PTR_NULL) || csi_is_port(cur_ptr);

	// Stack memory: write at sp on push; the read port follows sp
	// Read is registered, so the popped entry shows one cycle after the pointer steps back
	assign sif.wr_en   = push;
	assign sif.wr_addr = st.sp;
	assign sif.wr_data = pc_in;
	assign sif.rd_addr = st.sp;

	// ----------------------------------------
	// Next state
	// ----------------------------------------
	always_comb begin
		next_st = st;
		next_st.mem_rd = 1'b0;
		next_st.mem_wr = 1'b0;
		next_st.ind_rd_valid = 1'b0;
		next_st.zero_flag_set = 1'b0;
		next_st.rd_pend = 1'b0;
		next_st.pop_pend = 1'b0;
		next_st.pc_pop_valid = st.pop_pend;

		// Stack pointer, no software path pc latch not touched
		if (push && !pop) begin
			next_st.sp = st.sp + 4'h1;
			if (st.sp == csi_pkg::SP_TOP) begin
				next_st.locked = 1'b1;
			end
			if (st.popped && !st.pushed) begin
				next_st.locked = 1'b1;
			end
			next_st.pushed = 1'b1;
			next_st.popped = 1'b0;
		end else if (pop && !push) begin
			next_st.sp = st.sp - 4'h1;
			next_st.pop_pend = 1'b1;
			// Only a pop with no push since reset counts toward the early-pop lock
			next_st.popped = !st.pushed;
		end
		// Underflow lands the pointer on Fh, which clears the flag
		next_st.avail = !next_st.locked && (next_st.sp != csi_pkg::SP_TOP);

		// Indirect access, single cycle toward memory
		if (ind_rd || ind_wr) begin
			if (!bad_tgt) begin
				next_st.mem_addr = cur_ptr;
				next_st.mem_bank = bank_select_value;
				next_st.mem_rd = ind_rd;
				next_st.mem_wr = ind_wr;
				next_st.mem_wr_data = ind_wr_data;
			end
			next_st.rd_pend = ind_rd;
			next_st.rd_null = bad_tgt;
			// Pointer steps after access; no status bit is touched
			if (ind_sel) begin
				next_st.p1 = csi_step(st.p1, cur_mode);
			end else begin
				next_st.p0 = csi_step(st.p0, cur_mode);
			end
		end
		if (ptr0_wr) begin
			next_st.p0 = ptr_wr_data;
		end
		if (ptr1_wr) begin
			next_st.p1 = ptr_wr_data;
		end
		if (st.rd_pend) begin
			next_st.ind_rd_valid = 1'b1;
			next_st.ind_rd_data = st.rd_null ? 8'h00 : mem_rd_data;
			next_st.zero_flag_set = st.rd_null || (mem_rd_data == 8'h00);
		end

		// Table pointer and latch
		if (table_pointer_step) begin
			next_st.tptr = st.tptr + 16'h0001;
		end
		if (table_pointer_low_wr) begin
			next_st.tptr[7:0] = tbl_wr_data;
		end
		if (table_pointer_high_wr) begin
			next_st.tptr[15:8] = tbl_wr_data;
		end
		if (table_latch_load) begin
			next_st.tlat = table_latch_load_data;
		end
		if (table_latch_low_wr) begin
			next_st.tlat[7:0] = tbl_wr_data;
		end
		if (table_latch_high_wr) begin
			next_st.tlat[15:8] = tbl_wr_data;
		end
	end

	always_ff @(posedge clk_sys or posedge sys_rst) begin
		if (sys_rst) begin
			st <= '0;
			st.sp <= csi_pkg::SP_RESET;
			st.avail <= 1'b1;
			st.p0 <= csi_pkg::PTR_RESET;
			st.p1 <= csi_pkg::PTR_RESET;
			st.tptr <= csi_pkg::TBL_RESET;
			st.tlat <= csi_pkg::TBL_RESET;
		end else begin
			st <= next_st;
		end
	end

	// ----------------------------------------
	// Outputs
	// ----------------------------------------
	assign pc_pop = sif.rd_data; // registered inside the memory
	assign pc_pop_valid = st.pc_pop_valid;
	assign stack_available_flag = st.avail;
	assign indirect_pointer_zero = st.p0;
	assign indirect_pointer_one = st.p1;
	assign mem_addr = st.mem_addr;
	assign mem_bank = st.mem_bank;
	assign mem_rd = st.mem_rd;
	assign mem_wr = st.mem_wr;
	assign mem_wr_data = st.mem_wr_data;
	assign ind_rd_data = st.ind_rd_data;
	assign ind_rd_valid = st.ind_rd_valid;
	assign zero_flag_set = st.zero_flag_set;
	assign table_pointer_low = st.tptr[7:0];
	assign table_pointer_high = st.tptr[15:8];
	assign table_pointer = st.tptr;
	assign table_latch_high = st.tlat[15:8];
	assign table_latch_low = st.tlat[7:0];
	assign table_latch = st.tlat;

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_sp_top_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(st.sp == csi_pkg::SP_TOP) |-> !st.avail)
		else $error("flag set while pointer at top");
	a_wrap_locks: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(push && !pop && st.sp == csi_pkg::SP_TOP) |=> (!st.avail && st.locked)[*3])
		else $error("wrap did not lock flag");
	a_push_advances: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(push && !pop) |=> st.sp == $past(st.sp) + 4'h1)
		else $error("push did not advance pointer");
	a_pop_returns: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(push && !pop ##1 pop && !push) |=> ##1 (pc_pop_valid && pc_pop == $past(pc_in, 3)))
		else $error("pop returned wrong entry");
	a_pop_first_clears: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(pop && !push && !st.pushed && !st.popped) |=> !stack_available_flag)
		else $error("early pop left flag set");
	a_null_read_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(ind_rd && bad_tgt) |=> ##1 (ind_rd_valid && ind_rd_data == 8'h00 && zero_flag_set))
		else $error("null read not zero");
	a_null_write_nop: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(ind_wr && bad_tgt) |=> !mem_wr)
		else $error("write to port reached memory");
	a_step_inc: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(ind_rd && !ind_sel && cur_mode == csi_pkg::STEP_INC && !ptr0_wr) |=> st.p0 == $past(st.p0) + 8'h01)
		else $error("pointer zero not incremented");
	a_step_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		((ind_rd || ind_wr) && ind_sel && cur_mode[1] && !ptr1_wr) |=> $stable(st.p1))
		else $error("pointer one moved in hold mode");
	a_step_no_zero: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(ind_wr && !ind_rd && !st.rd_pend) |=> !zero_flag_set)
		else $error("stepping raised zero flag");
	a_access_single: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(ind_wr && !bad_tgt) |=> (mem_wr && mem_addr == $past(cur_ptr)))
		else $error("indirect write not in one cycle");
	a_tbl_ptr_step: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(table_pointer_step && !table_pointer_low_wr && !table_pointer_high_wr) |=>
		table_pointer == $past(table_pointer) + 16'h0001)
		else $error("table pointer did not step");
	a_pop_steps_back: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(pop && !push) |=> st.sp == $past(st.sp) - 4'h1)
		else $error("pop did not step pointer back");
	a_lock_sticks: assert property (@(posedge clk_sys) disable iff (sys_rst)
		st.locked |=> st.locked)
		else $error("lock released without reset");
	a_locked_clear: assert property (@(posedge clk_sys) disable iff (sys_rst)
		st.locked |-> !stack_available_flag)
		else $error("flag set while locked");
	a_flag_tracks: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(!st.locked && st.sp != csi_pkg::SP_TOP) |-> stack_available_flag)
		else $error("flag clear below top");
	a_step_dec: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(ind_rd && !ind_sel && cur_mode == csi_pkg::STEP_DEC && !ptr0_wr) |=> st.p0 == $past(st.p0) - 8'h01)
		else $error("pointer zero not decremented");
	a_p0_hold: assert property (@(posedge clk_sys) disable iff (sys_rst)
		((ind_rd || ind_wr) && !ind_sel && cur_mode[1] && !ptr0_wr) |=> $stable(st.p0))
		else $error("pointer zero moved in hold mode");
	a_read_data: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(ind_rd && !bad_tgt) |=> ##1 (ind_rd_valid && ind_rd_data == $past(mem_rd_data)))
		else $error("indirect read data lost");
	a_read_target: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(ind_rd && !bad_tgt) |=> (mem_rd && mem_addr == $past(cur_ptr) && mem_bank == $past(bank_select_value)))
		else $error("indirect read went to wrong place");
	a_null_no_read: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(ind_rd && bad_tgt) |=> !mem_rd)
		else $error("null read reached memory");
	a_ptr_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
		ptr1_wr |=> st.p1 == $past(ptr_wr_data))
		else $error("pointer one load lost");
	a_tbl_low_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		table_pointer_low_wr |=> table_pointer_low == $past(tbl_wr_data))
		else $error("table pointer low write lost");
	a_tlat_load: assert property (@(posedge clk_sys) disable iff (sys_rst)
		(table_latch_load && !table_latch_low_wr && !table_latch_high_wr) |=>
		table_latch == $past(table_latch_load_data))
		else $error("table latch load lost");
	a_tlat_high_write: assert property (@(posedge clk_sys) disable iff (sys_rst)
		table_latch_high_wr |=> table_latch_high == $past(tbl_wr_data))
		else $error("table latch high write lost");
endmodule

/* File: dv/csi_dmem_model.sv */
`timescale 1ns/1ps
module csi_dmem_model (
	input  wire logic       clk_sys,
	input  wire logic [7:0] mem_addr,
	input  wire logic       mem_rd,
	input  wire logic       mem_wr,
	input  wire logic [7:0] mem_wr_data,
	output logic      [7:0] mem_rd_data
);
	logic [7:0] store [256];

	initial for (int i = 0; i < 256; i++) store[i] = 8'(i) ^ 8'h3c;

	// Inverse data outside a read, so a sample in the wrong cycle shows up
	assign mem_rd_data = mem_rd ? store[mem_addr] : ~store[mem_addr];

	always @(posedge clk_sys) if (mem_wr) store[mem_addr] <= mem_wr_data;
endmodule

/* File: dv/csi_core_tb.sv */
`timescale 1ns/1ps
module csi_core_tb;
	logic        clk_sys = 1'h0, sys_rst = 1'h1, call_exec = 1'h0, intr_vector = 1'h0, return_exec = 1'h0;
	logic        return_with_literal_instr = 1'h0, interrupt_return_instr = 1'h0, ptr0_wr = 1'h0, ptr1_wr = 1'h0;
	logic        ind_rd = 1'h0, ind_wr = 1'h0, ind_sel = 1'h0, table_latch_load = 1'h0, table_pointer_step = 1'h0;
	logic        table_pointer_low_wr = 1'h0, table_pointer_high_wr = 1'h0, table_latch_low_wr = 1'h0;
	logic        table_latch_high_wr = 1'h0, pc_pop_valid, stack_available_flag, mem_rd, mem_wr;
	logic        ind_rd_valid, zero_flag_set;
	logic [7:0]  arithmetic_status_register = 8'h00, bank_select_value = 8'h00, ptr_wr_data = 8'h00;
	logic [7:0]  ind_wr_data = 8'h00, tbl_wr_data = 8'h00, mem_rd_data, indirect_pointer_zero, indirect_pointer_one;
	logic [7:0]  mem_addr, mem_bank, mem_wr_data, ind_rd_data, table_pointer_low, table_pointer_high;
	logic [7:0]  table_latch_high, table_latch_low;
	logic [15:0] pc_in = 16'h0000, table_latch_load_data = 16'h0000, pc_pop, table_pointer, table_latch;
	int          bad_count = 0, n_tests = 0, cyc = 0;

	always #25 clk_sys = ~clk_sys;

	csi_core i_dut (.clk_sys, .sys_rst, .call_exec, .intr_vector, .return_exec, .return_with_literal_instr,
		.interrupt_return_instr, .pc_in, .pc_pop, .pc_pop_valid, .stack_available_flag, .arithmetic_status_register,
		.bank_select_value, .ptr0_wr, .ptr1_wr, .ptr_wr_data, .ind_rd, .ind_wr, .ind_sel, .ind_wr_data, .mem_rd_data,
		.indirect_pointer_zero, .indirect_pointer_one, .mem_addr, .mem_bank, .mem_rd, .mem_wr, .mem_wr_data,
		.ind_rd_data, .ind_rd_valid, .zero_flag_set, .table_pointer_low_wr, .table_pointer_high_wr, .tbl_wr_data,
		.table_latch_low_wr, .table_latch_high_wr, .table_latch_load, .table_latch_load_data, .table_pointer_step,
		.table_pointer_low, .table_pointer_high, .table_pointer, .table_latch_high, .table_latch_low, .table_latch);

	csi_dmem_model i_mem (.clk_sys, .mem_addr, .mem_rd, .mem_wr, .mem_wr_data, .mem_rd_data);

	// ----------------------------------------
	// Reporting
	// ----------------------------------------
	task chk(input logic [47:0] got, input logic [47:0] exp);
		n_tests++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task print_verdict();
		$display("comparisons %0d mismatches %0d", n_tests, bad_count);
		if (bad_count == 0 && n_tests > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask

	// Whole run needs well under a thousand cycles
	always @(posedge clk_sys) begin
		cyc++;
		if (cyc == 3000) begin
			bad_count++;
			print_verdict();
		end
	end

	// ----------------------------------------
	// Access tasks
	// ----------------------------------------
	task tick(input int n = 1);
		repeat (n) @(posedge clk_sys);
		#1;
	endtask

	task do_reset();
		@(posedge clk_sys) sys_rst <= 1'h1;
		repeat (5) @(posedge clk_sys);
		sys_rst <= 1'h0;
		tick();
		chk(stack_available_flag, 1);
		chk({table_pointer, table_latch, indirect_pointer_zero, indirect_pointer_one}, 0);
	endtask

	task push(input logic irq, input logic [15:0] v);
		@(posedge clk_sys);
		call_exec <= !irq;
		intr_vector <= irq;
		pc_in <= v;
		@(posedge clk_sys);
		call_exec <= 1'h0;
		intr_vector <= 1'h0;
		tick();
	endtask

	task pop(input int k, input logic [15:0] exp, input logic cmp);
		@(posedge clk_sys);
		{return_exec, return_with_literal_instr, interrupt_return_instr} <= 3'h4 >> k;
		@(posedge clk_sys);
		{return_exec, return_with_literal_instr, interrupt_return_instr} <= 3'h0;
		// Valid stands for the single cycle after the pointer steps back
		tick();
		chk(pc_pop_valid, 1);
		if (cmp) chk(pc_pop, exp);
	endtask

	task ptr(input logic sel, input logic [7:0] v, input logic [7:0] asr);
		@(posedge clk_sys);
		ptr0_wr <= !sel;
		ptr1_wr <= sel;
		ptr_wr_data <= v;
		arithmetic_status_register <= asr;
		@(posedge clk_sys);
		ptr0_wr <= 1'h0;
		ptr1_wr <= 1'h0;
	endtask

	task ind(input logic wr, input logic sel, input logic [7:0] wd, input logic [7:0] ea, input logic ok,
		input logic [7:0] ed);
		@(posedge clk_sys);
		ind_rd <= !wr;
		ind_wr <= wr;
		ind_sel <= sel;
		ind_wr_data <= wd;
		@(posedge clk_sys);
		ind_rd <= 1'h0;
		ind_wr <= 1'h0;
		// Memory strobes stand one cycle only, so look before the next edge
		#1;
		chk(mem_rd, ok & !wr);
		chk(mem_wr, ok & wr);
		if (ok) chk({mem_bank, mem_addr}, {bank_select_value, ea});
		if (ok & wr) chk(mem_wr_data, wd);
		tick();
		chk(ind_rd_valid, !wr);
		chk(zero_flag_set, !wr & (ed == 8'h00));
		if (!wr) chk(ind_rd_data, ed);
	endtask

	task tbl(input logic [5:0] s, input logic [7:0] d);
		@(posedge clk_sys);
		{table_pointer_step, table_latch_load, table_latch_high_wr, table_latch_low_wr} <= s[5:2];
		{table_pointer_high_wr, table_pointer_low_wr} <= s[1:0];
		tbl_wr_data <= d;
		table_latch_load_data <= {d, ~d};
		@(posedge clk_sys);
		{table_pointer_step, table_latch_load, table_latch_high_wr, table_latch_low_wr} <= 4'h0;
		{table_pointer_high_wr, table_pointer_low_wr} <= 2'h0;
		tick();
	endtask

	function automatic logic [7:0] stepped(input logic [7:0] v, input int m);
		return (m == 0) ? v - 8'h01 : (m == 1) ? v + 8'h01 : v;
	endfunction

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		do_reset();
		push(0, 16'h1234);
		push(1, 16'habcd);
		push(0, 16'h00ff);
		pop(0, 16'h00ff, 1);
		pop(1, 16'habcd, 1);
		pop(2, 16'h1234, 1);
		// Sixteen pushes wrap the pointer, the seventeenth overwrites entry zero
		for (int i = 1; i <= 17; i++) begin
			push(0, 16'(i));
			if (i < 16) chk(stack_available_flag, i < 15);
		end
		chk(stack_available_flag, 0);
		pop(0, 16'h0011, 1);
		pop(0, 16'h0010, 1);
		chk(stack_available_flag, 0);
		do_reset();
		pop(0, 16'h0000, 0);
		chk(stack_available_flag, 0);
		push(1, 16'h5555);
		chk(stack_available_flag, 0);
		pop(1, 16'h5555, 1);
		// Push and pop on neighbouring edges: the entry just written comes straight back
		@(posedge clk_sys) {call_exec, pc_in} <= {1'h1, 16'h6a6a};
		@(posedge clk_sys) {call_exec, return_exec} <= 2'h1;
		@(posedge clk_sys) return_exec <= 1'h0;
		tick();
		chk({pc_pop_valid, pc_pop}, {1'h1, 16'h6a6a});
		chk(stack_available_flag, 0);
		@(posedge clk_sys) bank_select_value <= 8'h3a;
		for (int m = 0; m < 4; m++) begin
			ptr(0, 8'h20, {2'(3 - m), 2'(m), 4'h5});
			ptr(1, 8'h30, {2'(3 - m), 2'(m), 4'h5});
			ind(0, 0, 8'h00, 8'h20, 1, 8'h1c);
			chk(indirect_pointer_zero, stepped(8'h20, m));
			ind(0, 1, 8'h00, 8'h30, 1, 8'h0c);
			chk(indirect_pointer_one, stepped(8'h30, 3 - m));
		end
		ptr(0, 8'h01, 8'h20);
		ind(0, 0, 8'h00, 8'h01, 1, 8'h3d);
		ptr(0, 8'h00, 8'h20);
		ind(0, 0, 8'h00, 8'h00, 0, 8'h00);
		ind(1, 0, 8'h99, 8'h00, 0, 8'h00);
		ptr(1, 8'h08, 8'hf0);
		ind(0, 1, 8'h00, 8'h08, 0, 8'h00);
		ind(1, 1, 8'h99, 8'h08, 0, 8'h00);
		ptr(0, 8'h3c, 8'hf0);
		ind(0, 0, 8'h00, 8'h3c, 1, 8'h00);
		ind(1, 0, 8'h77, 8'h3c, 1, 8'h00);
		ind(0, 0, 8'h00, 8'h3c, 1, 8'h77);
		tbl(6'h01, 8'h12);
		tbl(6'h02, 8'hab);
		chk({table_pointer, table_pointer_high, table_pointer_low}, 32'hab12ab12);
		tbl(6'h20, 8'h00);
		chk(table_pointer, 16'hab13);
		tbl(6'h04, 8'h5c);
		tbl(6'h08, 8'hc5);
		chk({table_latch, table_latch_high, table_latch_low}, 32'hc55cc55c);
		tbl(6'h10, 8'h3e);
		chk(table_latch, 16'h3ec1);
		print_verdict();
	end
endmodule
